// *** hw/irq_line_router.sv ***
`timescale 1ns/1ns
`default_nettype none
module irq_line_router #(
  parameter int SOURCES = 3
) (
  input wire logic [SOURCES-1:0] flags,
  input wire logic [SOURCES-1:0] enables,
  input wire logic [SOURCES-1:0] selects,
  output logic line_zero,
  output logic line_one
);

  logic [SOURCES-1:0] to_zero;
  logic [SOURCES-1:0] to_one;

  // Elaboration check on source count
  if (SOURCES < 1) begin : g_bad_sources
    $error("SOURCES must be at least 1");
  end

  // --------------------------------------------------------------
  // Per-source gating and steering
  // --------------------------------------------------------------
  for (genvar i = 0; i < SOURCES; i++) begin : g_src
    assign to_zero[i] = flags[i] & enables[i] & ~selects[i];
    assign to_one[i] = flags[i] & enables[i] & selects[i];
  end

  // Line is OR of enabled sources steered to it
  assign line_zero = |to_zero; // [RULE14]
  assign line_one = |to_one; // [RULE14]

endmodule
`default_nettype wire

// *** hw/spi_irq_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
module spi_irq_ctrl #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Shift engine events
  input wire logic word_received,
  input wire logic receive_buffer_read,
  input wire logic bit_error_flag,
  input wire logic rx_data_ready,
  input wire logic tx_space_ready,
  // Outputs to interrupt and DMA controllers
  output logic irq_line_zero,
  output logic irq_line_one,
  output logic rx_dma_req,
  output logic tx_dma_req
);

  // Elaboration check on address width
  if (ADDR_W < 4 || ADDR_W > 12) begin : g_bad_addr_w
    $error("ADDR_W must lie in 4..12");
  end

  // Address to register decode
  function automatic spi_irq_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [11:0] a;
    a = 12'(addr);
    unique case (a)
      spi_irq_pkg::GLOBAL_CONTROL_ONE_OFS: decode = spi_irq_pkg::SEL_GLOBAL;
      spi_irq_pkg::INTERRUPT_SOURCE_ENABLE_OFS: decode = spi_irq_pkg::SEL_ENABLE;
      spi_irq_pkg::INTERRUPT_LINE_SELECT_OFS: decode = spi_irq_pkg::SEL_LINE;
      spi_irq_pkg::EVENT_FLAG_REGISTER_OFS: decode = spi_irq_pkg::SEL_FLAGS;
      default: decode = spi_irq_pkg::SEL_NONE;
    endcase
  endfunction

  // Byte-lane merge limited to writable bits
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = ((old & ~lanes) | (data & lanes)) & mask;
  endfunction

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  logic aw_pend_reg, aw_pend_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic w_pend_reg, w_pend_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] gctl_reg, gctl_next;
  logic [31:0] enable_reg, enable_next;
  logic [31:0] select_reg, select_next;
  logic rx_flag_reg, rx_flag_next;
  logic ovr_flag_reg, ovr_flag_next;
  logic line0_reg, line0_next;
  logic line1_reg, line1_next;
  logic rx_dma_reg, rx_dma_next;
  logic tx_dma_reg, tx_dma_next;

  logic do_write;
  logic run_enable;
  logic [31:0] flag_word;
  logic [2:0] src_flags;
  logic [2:0] src_enables;
  logic [2:0] src_selects;
  logic route_zero;
  logic route_one;

  assign run_enable = gctl_reg[spi_irq_pkg::MODULE_RUN_ENABLE_BIT];
  assign do_write = aw_pend_reg && w_pend_reg && !bvalid_reg;

  // Flag register image
  always_comb begin
    flag_word = 32'h0000_0000;
    flag_word[spi_irq_pkg::RECEIVE_BIT] = rx_flag_reg;
    flag_word[spi_irq_pkg::OVERRUN_BIT] = ovr_flag_reg;
    flag_word[spi_irq_pkg::BIT_ERROR_BIT] = bit_error_flag;
  end

  // --------------------------------------------------------------
  // Bus, register and flag next state
  // --------------------------------------------------------------
  always_comb begin
    aw_pend_next = aw_pend_reg;
    awaddr_next = awaddr_reg;
    w_pend_next = w_pend_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    gctl_next = gctl_reg;
    enable_next = enable_reg;
    select_next = select_reg;
    rx_flag_next = rx_flag_reg;
    ovr_flag_next = ovr_flag_reg;
    // Address and data captured in either order
    if (s_axi_awvalid && awready_reg) begin
      aw_pend_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_pend_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // Flag clears from software and buffer read
    if (receive_buffer_read) begin
      rx_flag_next = 1'b0;
    end
    if (do_write) begin
      aw_pend_next = 1'b0;
      w_pend_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = spi_irq_pkg::RESP_OKAY;
      unique case (decode(awaddr_reg))
        spi_irq_pkg::SEL_GLOBAL:
          gctl_next = merge(gctl_reg, wdata_reg, wstrb_reg, spi_irq_pkg::GLOBAL_CONTROL_ONE_MASK);
        spi_irq_pkg::SEL_ENABLE: // [RULE9]
          enable_next = merge(enable_reg, wdata_reg, wstrb_reg, spi_irq_pkg::INTERRUPT_SOURCE_ENABLE_MASK);
        spi_irq_pkg::SEL_LINE: // [RULE9]
          select_next = merge(select_reg, wdata_reg, wstrb_reg, spi_irq_pkg::INTERRUPT_LINE_SELECT_MASK);
        spi_irq_pkg::SEL_FLAGS: begin
          // Write one to clear
          if (wstrb_reg[1] && wdata_reg[spi_irq_pkg::RECEIVE_BIT]) begin
            rx_flag_next = 1'b0;
          end
          if (wstrb_reg[0] && wdata_reg[spi_irq_pkg::OVERRUN_BIT]) begin
            ovr_flag_next = 1'b0;
          end
        end
        spi_irq_pkg::SEL_NONE: bresp_next = spi_irq_pkg::RESP_SLVERR;
      endcase
    end
    // Hardware set wins over software and buffer-read clears
    if (word_received) begin
      rx_flag_next = 1'b1; // [RULE11]
      if (rx_flag_reg && !receive_buffer_read) begin
        ovr_flag_next = 1'b1; // [RULE12]
      end
    end
    // Run enable low forces both flags clear
    if (!gctl_next[spi_irq_pkg::MODULE_RUN_ENABLE_BIT] || !run_enable) begin
      rx_flag_next = 1'b0; // [RULE13]
      ovr_flag_next = 1'b0; // [RULE13]
    end
    // Read channel
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = spi_irq_pkg::RESP_OKAY;
      unique case (decode(s_axi_araddr))
        spi_irq_pkg::SEL_GLOBAL: rdata_next = gctl_reg;
        spi_irq_pkg::SEL_ENABLE: rdata_next = enable_reg; // [RULE9]
        spi_irq_pkg::SEL_LINE: rdata_next = select_reg; // [RULE9]
        spi_irq_pkg::SEL_FLAGS: rdata_next = flag_word;
        spi_irq_pkg::SEL_NONE: begin
          rdata_next = 32'h0000_0000;
          rresp_next = spi_irq_pkg::RESP_SLVERR;
        end
      endcase
    end
    awready_next = !aw_pend_next;
    wready_next = !w_pend_next;
  end

  // Source vectors: receive, overrun, bit error
  assign src_flags = {rx_flag_reg, ovr_flag_reg, bit_error_flag};
  assign src_enables = {enable_reg[spi_irq_pkg::RECEIVE_BIT],    // [RULE3]
                        enable_reg[spi_irq_pkg::OVERRUN_BIT],    // [RULE4]
                        enable_reg[spi_irq_pkg::BIT_ERROR_BIT]}; // [RULE5]
  assign src_selects = {select_reg[spi_irq_pkg::RECEIVE_BIT],    // [RULE6]
                        select_reg[spi_irq_pkg::OVERRUN_BIT],    // [RULE7]
                        select_reg[spi_irq_pkg::BIT_ERROR_BIT]}; // [RULE8]

  // Gate and steer each source
  irq_line_router #(
    .SOURCES(spi_irq_pkg::NUM_SOURCES)
  ) u_router (
    .flags(src_flags),
    .enables(src_enables),
    .selects(src_selects),
    .line_zero(route_zero),
    .line_one(route_one)
  );

  // Output next values
  always_comb begin
    line0_next = route_zero; // [RULE14]
    line1_next = route_one; // [RULE14]
    rx_dma_next = enable_reg[spi_irq_pkg::DMA_REQUEST_ENABLE_BIT] & rx_data_ready; // [RULE1]
    tx_dma_next = enable_reg[spi_irq_pkg::DMA_REQUEST_ENABLE_BIT] & tx_space_ready; // [RULE1]
  end

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_pend_reg <= 1'b0;
      awaddr_reg <= '0;
      w_pend_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
      gctl_reg <= spi_irq_pkg::GLOBAL_CONTROL_ONE_RST;
      enable_reg <= spi_irq_pkg::INTERRUPT_SOURCE_ENABLE_RST; // [RULE15]
      select_reg <= spi_irq_pkg::INTERRUPT_LINE_SELECT_RST; // [RULE15]
      rx_flag_reg <= 1'b0;
      ovr_flag_reg <= 1'b0;
      line0_reg <= 1'b0;
      line1_reg <= 1'b0;
      rx_dma_reg <= 1'b0;
      tx_dma_reg <= 1'b0;
    end else begin
      aw_pend_reg <= aw_pend_next;
      awaddr_reg <= awaddr_next;
      w_pend_reg <= w_pend_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      gctl_reg <= gctl_next;
      enable_reg <= enable_next;
      select_reg <= select_next;
      rx_flag_reg <= rx_flag_next;
      ovr_flag_reg <= ovr_flag_next;
      line0_reg <= line0_next;
      line1_reg <= line1_next;
      rx_dma_reg <= rx_dma_next;
      tx_dma_reg <= tx_dma_next;
    end
  end

  // Ports straight from flip-flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign irq_line_zero = line0_reg;
  assign irq_line_one = line1_reg;
  assign rx_dma_req = rx_dma_reg;
  assign tx_dma_req = tx_dma_reg;

endmodule
`default_nettype wire

// *** hw/spi_irq_pkg.sv ***
// Function
// (RULE1) DMA enable bit 16 gates both requests
// (RULE2) Software readies DMA channels before enabling
// (RULE3) Receive enable bit 8 gates word interrupt
// (RULE4) Overrun enable bit 6 gates overrun interrupt
// (RULE5) Bit error enable bit 4 gates error interrupt
// (RULE6) Select bit 8 steers receive interrupt line
// (RULE7) Select bit 6 steers overrun interrupt line
// (RULE8) Select bit 4 steers bit error line
// (RULE9) Reserved bits read zero, writes ignored
// (RULE10) Software writes zeros into reserved bits
// (RULE11) Received word sets the received-word flag
// (RULE12) Word before buffer read sets overrun flag
// (RULE13) Run enable low holds both flags clear
// (RULE14) Each line ORs enabled sources selected there
// (RULE15) Reset clears every enable and select bit
package spi_irq_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] GLOBAL_CONTROL_ONE_OFS = 12'h000;
  localparam logic [11:0] INTERRUPT_SOURCE_ENABLE_OFS = 12'h004;
  localparam logic [11:0] INTERRUPT_LINE_SELECT_OFS = 12'h008;
  localparam logic [11:0] EVENT_FLAG_REGISTER_OFS = 12'h00c;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MODULE_RUN_ENABLE_BIT = 24;
  localparam int DMA_REQUEST_ENABLE_BIT = 16;
  localparam int RECEIVE_BIT = 8;
  localparam int OVERRUN_BIT = 6;
  localparam int BIT_ERROR_BIT = 4;

  // Writable bits per register; everything else reads zero
  localparam logic [31:0] GLOBAL_CONTROL_ONE_MASK = 32'h0100_0000;
  localparam logic [31:0] INTERRUPT_SOURCE_ENABLE_MASK = 32'h0001_0150;
  localparam logic [31:0] INTERRUPT_LINE_SELECT_MASK = 32'h0000_0150;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] GLOBAL_CONTROL_ONE_RST = 32'h0000_0000;
  localparam logic [31:0] INTERRUPT_SOURCE_ENABLE_RST = 32'h0000_0000;
  localparam logic [31:0] INTERRUPT_LINE_SELECT_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Bus responses and source count
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NUM_SOURCES = 3;

  // Register selected by an address
  typedef enum {
    SEL_GLOBAL,
    SEL_ENABLE,
    SEL_LINE,
    SEL_FLAGS,
    SEL_NONE
  } reg_sel_t;

endpackage

// *** verif/irq_dma_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module irq_dma_host (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic armed,
  input wire logic rx_req,
  input wire logic tx_req,
  output logic stray
);
  // Notes requests reaching channels not yet armed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stray <= 1'h0;
    end else if ((rx_req || tx_req) && !armed) begin
      stray <= 1'h1;
    end
  end
endmodule
`default_nettype wire

// *** verif/spi_interrupt_enable_routing_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module spi_interrupt_enable_routing_bench;
  localparam logic [11:0] gc_a = spi_irq_pkg::GLOBAL_CONTROL_ONE_OFS;
  localparam logic [11:0] en_a = spi_irq_pkg::INTERRUPT_SOURCE_ENABLE_OFS;
  localparam logic [11:0] sel_a = spi_irq_pkg::INTERRUPT_LINE_SELECT_OFS;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic word_received = 1'h0, receive_buffer_read = 1'h0, bit_error_flag = 1'h0;
  logic rx_data_ready = 1'h0, tx_space_ready = 1'h0;
  logic irq_line_zero, irq_line_one, rx_dma_req, tx_dma_req, stray;
  logic pr = 1'h0, armed = 1'h0;
  logic [33:0] q[$];
  logic [33:0] e;
  int bad_count = 0, comparisons = 0;
  integer seed = 32'hcb49;

  // Clock
  always #10 clk = ~clk;
  spi_irq_ctrl i_dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .word_received(word_received), .receive_buffer_read(receive_buffer_read),
    .bit_error_flag(bit_error_flag), .rx_data_ready(rx_data_ready), .tx_space_ready(tx_space_ready),
    .irq_line_zero(irq_line_zero), .irq_line_one(irq_line_one), .rx_dma_req(rx_dma_req),
    .tx_dma_req(tx_dma_req));
  irq_dma_host i_host (.clk(clk), .rst_n(rst_n), .armed(armed), .rx_req(rx_dma_req), .tx_req(tx_dma_req),
    .stray(stray));

  // ------
  // Shared tasks
  // ------
  task check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task results;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    bit ao, wo;
    ao = 0;
    wo = 0;
    // Mapped registers answer OKAY, anything past the flag register SLVERR
    q.push_back({a > spi_irq_pkg::EVENT_FLAG_REGISTER_OFS ? spi_irq_pkg::RESP_SLVERR : spi_irq_pkg::RESP_OKAY, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(ao && wo)) begin
      @(posedge clk);
      if (!ao && s_axi_awready) begin
        ao = 1;
        s_axi_awvalid <= 1'h0;
      end
      if (!wo && s_axi_wready) begin
        wo = 1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
  endtask

  task rd(input logic [11:0] a, input logic [33:0] x);
    q.push_back(x);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (!s_axi_rvalid);
  endtask

  task probe(input logic [3:0] x);
    repeat (2) @(posedge clk);
    q.push_back({30'h0, x});
    pr <= 1'h1;
    @(posedge clk);
    pr <= 1'h0;
    @(posedge clk);
  endtask

  task pulse(input int n);
    word_received <= 1'h1;
    repeat (n) @(posedge clk);
    word_received <= 1'h0;
    @(posedge clk);
  endtask

  // Compares each answer or probe with the oldest note
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      e = q.pop_front();
      check({s_axi_bresp, 32'h0}, e);
    end
    if (s_axi_rvalid && s_axi_rready) begin
      e = q.pop_front();
      check({s_axi_rresp, s_axi_rdata}, e);
    end
    if (pr) begin
      e = q.pop_front();
      check({30'h0, rx_dma_req, tx_dma_req, irq_line_one, irq_line_zero}, e);
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  // Main sequence
  initial begin
    int s, sel, en, b, r;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(en_a, 34'h0);
    rd(sel_a, 34'h0);
    $display("reset values done");
    wr(en_a, 32'h0001_fff0);
    rd(en_a, {2'h0, spi_irq_pkg::INTERRUPT_SOURCE_ENABLE_MASK});
    wr(sel_a, 32'hffff_fff0);
    rd(sel_a, {2'h0, spi_irq_pkg::INTERRUPT_LINE_SELECT_MASK});
    rd(12'h020, {spi_irq_pkg::RESP_SLVERR, 32'h0});
    wr(12'h020, 32'h0);
    $display("reserved bits done");
    wr(gc_a, 32'h0100_0000);
    for (s = 0; s < 3; s++) begin
      for (sel = 0; sel < 2; sel++) begin
        for (en = 0; en < 2; en++) begin
          b = s == 0 ? spi_irq_pkg::RECEIVE_BIT : s == 1 ? spi_irq_pkg::OVERRUN_BIT : spi_irq_pkg::BIT_ERROR_BIT;
          wr(en_a, 32'(en) << b);
          wr(sel_a, 32'(sel) << b);
          if (s == 2) begin
            bit_error_flag <= 1'h1;
          end else begin
            pulse(s + 1);
          end
          probe({2'h0, en[0] & sel[0], en[0] & ~sel[0]});
          bit_error_flag <= 1'h0;
          receive_buffer_read <= 1'h1;
          @(posedge clk);
          receive_buffer_read <= 1'h0;
          wr(spi_irq_pkg::EVENT_FLAG_REGISTER_OFS, 32'h0000_0150);
        end
      end
    end
    $display("routing done");
    wr(en_a, 32'h0000_0150);
    wr(sel_a, 32'h0000_0100);
    bit_error_flag <= 1'h1;
    pulse(2);
    probe(4'h3);
    wr(gc_a, 32'h0);
    probe(4'h1);
    pulse(1);
    probe(4'h1);
    bit_error_flag <= 1'h0;
    $display("combine and run enable done");
    wr(en_a, 32'h0);
    for (s = 0; s < 16; s++) begin
      if (s == 8) begin
        armed <= 1'h1;
        wr(en_a, 32'h0001_0000);
      end
      r = $random(seed);
      rx_data_ready <= r[0];
      tx_space_ready <= r[1];
      probe({s >= 8 && r[0], s >= 8 && r[1], 2'h0});
    end
    check({33'h0, stray}, 34'h0);
    $display("dma requests done");
    results();
  end
endmodule
`default_nettype wire

// *** verif/spi_irq_ctrl_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module spi_irq_ctrl_asserts #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic rx_data_ready,
  input wire logic tx_space_ready,
  input wire logic irq_line_zero,
  input wire logic irq_line_one,
  input wire logic rx_dma_req,
  input wire logic tx_dma_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ------
  // Request gating and bus answers
  // ------
  a_rx_dma_gate: assert property (!rx_data_ready |=> !rx_dma_req) else $error("rx request without want");
  a_tx_dma_gate: assert property (!tx_space_ready |=> !tx_dma_req) else $error("tx request without want");
  a_dma_pair: assert property (rx_data_ready && tx_space_ready |=> rx_dma_req == tx_dma_req)
    else $error("dma requests disagree");
  a_reset_quiet: assert property ($rose(rst_n) |-> !irq_line_zero && !irq_line_one &&
    !rx_dma_req && !tx_dma_req) else $error("outputs active after reset");
  a_reserved_zero: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr == 4 || s_axi_araddr == 8)
    |=> (s_axi_rdata & ~spi_irq_pkg::INTERRUPT_SOURCE_ENABLE_MASK) == 32'h0) else $error("reserved bit read one");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken during answer");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 16
    |=> s_axi_rresp == spi_irq_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
endmodule
bind spi_irq_ctrl spi_irq_ctrl_asserts #(.ADDR_W(ADDR_W)) u_asserts (.clk, .rst_n, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .rx_data_ready, .tx_space_ready, .irq_line_zero,
  .irq_line_one, .rx_dma_req, .tx_dma_req);
`default_nettype wire
